/* spf_cpu_model.sv */
// processor-side model issuing special store and load strobes
`timescale 1ns/1ps
`default_nettype none
module spf_cpu_model (
	output var spf_pkg::spf_cpu_req_type cpuReq,
	input  wire logic                    ref_clk
);
	import spf_pkg::*;
	initial cpuReq = '0;
	// ==========================================
	// one strobe after lag cycles
	task automatic op(input logic st, input logic [16:0] z, input logic [15:0] d, input int lag);
		repeat (lag) @(posedge ref_clk);
		cpuReq.spm <= st;
		cpuReq.lpm <= !st;
		cpuReq.zPtr <= st ? {z[16:1], 1'b0} : z;
		cpuReq.r1r0 <= d;
		@(posedge ref_clk);
		// released operands flip so stale values cannot pass
		cpuReq <= {2'b00, ~z, ~d};
	endtask
endmodule
`default_nettype wire

/* spf_pkg.sv */
// constants, states and carriers of the self-programming flash control block
package spf_pkg;
	// ==========================================
	// control/status register
	localparam logic [7:0] CSR_DATA_OFS = 8'h57;
	localparam logic [7:0] CSR_IO_OFS   = 8'h37;
	localparam logic [7:0] CSR_RESET    = 8'h00;
	localparam int BIT_IRQ_EN  = 7;
	localparam int BIT_RWW_BSY = 6;
	localparam int BIT_SIG_RD  = 5;
	localparam int BIT_REEN    = 4;
	localparam int BIT_LOCK    = 3;
	localparam int BIT_PG_WR   = 2;
	localparam int BIT_PG_ER   = 1;
	localparam int BIT_EN      = 0;
	// legal patterns of bits 5:0
	localparam logic [5:0] PAT_LOAD = 6'h01;
	localparam logic [5:0] PAT_REEN = 6'h11;
	localparam logic [5:0] PAT_LOCK = 6'h09;
	localparam logic [5:0] PAT_PGWR = 6'h05;
	localparam logic [5:0] PAT_PGER = 6'h03;
	localparam logic [5:0] PAT_SIG  = 6'h21;
	// ==========================================
	// windows and timing
	localparam logic [2:0] SPM_WINDOW    = 3'h4;
	localparam logic [1:0] LPM_WINDOW    = 2'h3;
	localparam int         PROG_MIN_NS   = 3700000;
	localparam int         PROG_MAX_NS   = 4500000;
	localparam int         CLK_PERIOD_NS = 50;
	localparam int         PROG_CYCLES   = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================
	// flash map
	localparam logic [8:0]  HALT_FIRST_PAGE = 9'h1e0;
	localparam logic [15:0] BOOT_START_512  = 16'hfe00;
	localparam logic [15:0] BOOT_START_1K   = 16'hfc00;
	localparam logic [15:0] BOOT_START_2K   = 16'hf800;
	localparam logic [15:0] BOOT_START_4K   = 16'hf000;
	localparam logic [1:0]  ZSEL_FUSE_LOW   = 2'h0;
	localparam logic [1:0]  ZSEL_LOCK       = 2'h1;
	localparam logic [1:0]  ZSEL_FUSE_EXT   = 2'h2;
	localparam logic [1:0]  ZSEL_FUSE_HIGH  = 2'h3;
	// ==========================================
	// states and carriers
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_BUSY  = 3'b100
	} spf_state_type;

	typedef struct packed {
		logic        spm;
		logic        lpm;
		logic [16:0] zPtr;
		logic [15:0] r1r0;
	} spf_cpu_req_type;

	typedef struct packed {
		logic        erase;
		logic        write;
		logic        bufWrite;
		logic        bufAbort;
		logic        lockWrite;
		logic [8:0]  page;
		logic [6:0]  word;
		logic [15:0] data;
		logic [7:0]  lockData;
	} spf_flash_cmd_type;
endpackage

/* spf_self_program_flash_control.sv */
// self-programming sequencer for the on-chip program flash
`timescale 1ns/1ps
`default_nettype none

module spf_self_program_flash_control #(
	parameter int PROG_CYCLES = spf_pkg::PROG_CYCLES
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_b,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	input  wire logic                       regIsIo,
	input  wire logic [7:0]                 regAddr,
	input  wire logic [7:0]                 regWdata,
	output var  logic [7:0]                 regRdata,
	input  wire spf_pkg::spf_cpu_req_type   cpuReq,
	input  wire logic                       globalIrqEn,
	input  wire logic [1:0]                 bootSizeFuses,
	input  wire logic [7:0]                 sigRowByte,
	input  wire logic [7:0]                 lockBits,
	input  wire logic [7:0]                 fuseLow,
	input  wire logic [7:0]                 fuseHigh,
	input  wire logic [7:0]                 fuseExt,
	output var  logic [7:0]                 lpmData,
	output var  logic                       lpmValid,
	output var  logic                       cpuHalt,
	output var  logic                       rwwBlocked,
	output var  logic                       readyIrq,
	output var  logic [15:0]                bootStart,
	output var  spf_pkg::spf_flash_cmd_type flashCmd
);
	import spf_pkg::*;

	localparam int CNT_W = $clog2(PROG_CYCLES + 1);
	localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);

	typedef struct packed {
		spf_state_type     st;
		logic [7:0]        csr;
		logic [2:0]        spmWin;
		logic [1:0]        lpmWin;
		logic [CNT_W-1:0]  progCnt;
		logic              bufLoaded;
		logic              cpuHalt;
		logic              irq;
		logic [7:0]        rdata;
		logic [7:0]        lpmData;
		logic              lpmValid;
		logic [15:0]       bootStart;
		spf_flash_cmd_type fl;
	} spf_regs_type;

	localparam spf_regs_type REGS_RESET = '{st: ST_IDLE, csr: CSR_RESET, default: '0};

	spf_regs_type r;
	spf_regs_type n;
	logic         hit;

	// ==========================================
	// helpers
	function automatic logic patLegal(input logic [5:0] p);
		patLegal = (p == PAT_LOAD) || (p == PAT_REEN) || (p == PAT_LOCK) ||
			(p == PAT_PGWR) || (p == PAT_PGER) || (p == PAT_SIG);
	endfunction

	function automatic logic [15:0] bootStartOf(input logic [1:0] f);
		case (f)
			2'h3:    bootStartOf = BOOT_START_512;
			2'h2:    bootStartOf = BOOT_START_1K;
			2'h1:    bootStartOf = BOOT_START_2K;
			default: bootStartOf = BOOT_START_4K;
		endcase
	endfunction

	function automatic logic inHaltSection(input logic [8:0] page);
		inHaltSection = (page >= HALT_FIRST_PAGE);
	endfunction

	// both address spaces reach the same register
	assign hit = regIsIo ? (regAddr == CSR_IO_OFS) : (regAddr == CSR_DATA_OFS);

	// ==========================================
	// next state
	always_comb
	begin
		n = r;
		n.fl.erase = 1'b0;
		n.fl.write = 1'b0;
		n.fl.bufWrite = 1'b0;
		n.fl.bufAbort = 1'b0;
		n.fl.lockWrite = 1'b0;
		n.lpmValid = 1'b0;
		n.irq = r.csr[BIT_IRQ_EN] & globalIrqEn & ~r.csr[BIT_EN];
		n.bootStart = bootStartOf(bootSizeFuses);
		if (regRd && hit)
			n.rdata = r.csr;
		case (r.st)
			ST_IDLE:
			begin
				n.spmWin = '0;
				n.lpmWin = '0;
			end
			ST_ARMED:
			begin
				n.spmWin = r.spmWin - 3'h1;
				n.lpmWin = (r.lpmWin != 2'h0) ? r.lpmWin - 2'h1 : 2'h0;
				if (cpuReq.spm)
				begin
					n.csr[5:0] = 6'h00;
					n.st = ST_IDLE;
					case (r.csr[5:0])
						PAT_LOAD:
						begin
							// z bit 0 dropped, word picked by bits 7:1
							n.fl.bufWrite = 1'b1;
							n.fl.word = cpuReq.zPtr[7:1];
							n.fl.data = cpuReq.r1r0;
							n.csr[BIT_RWW_BSY] = 1'b0;
							n.bufLoaded = 1'b1;
						end
						PAT_REEN:
							n.csr[BIT_RWW_BSY] = 1'b0;
						PAT_LOCK:
						begin
							n.fl.lockWrite = 1'b1;
							n.fl.lockData = cpuReq.r1r0[7:0];
						end
						PAT_PGWR:
						begin
							n.fl.write = 1'b1;
							n.bufLoaded = 1'b0;
						end
						PAT_PGER:
							n.fl.erase = 1'b1;
						default:
							n.st = ST_IDLE;
					endcase
					if (r.csr[5:0] == PAT_LOCK || r.csr[5:0] == PAT_PGWR || r.csr[5:0] == PAT_PGER)
					begin
						// enable and command bit held until the timer expires
						n.csr[5:0] = r.csr[5:0];
						n.st = ST_BUSY;
						n.progCnt = PROG_LAST;
						if (r.csr[5:0] != PAT_LOCK)
						begin
							n.fl.page = cpuReq.zPtr[16:8];
							if (inHaltSection(cpuReq.zPtr[16:8]))
								n.cpuHalt = 1'b1;
							else
								n.csr[BIT_RWW_BSY] = 1'b1;
						end
					end
				end
				else if (cpuReq.lpm && r.lpmWin != 2'h0 && (r.csr[BIT_SIG_RD] || r.csr[BIT_LOCK]))
				begin
					n.lpmValid = 1'b1;
					if (r.csr[BIT_SIG_RD])
						n.lpmData = sigRowByte;
					else
						case (cpuReq.zPtr[1:0])
							ZSEL_FUSE_LOW: n.lpmData = fuseLow;
							ZSEL_LOCK:     n.lpmData = lockBits;
							ZSEL_FUSE_EXT: n.lpmData = fuseExt;
							default:       n.lpmData = fuseHigh;
						endcase
					n.csr[5:0] = 6'h00;
					n.st = ST_IDLE;
				end
				else if (r.spmWin == 3'h1 || (r.csr[BIT_SIG_RD] && r.lpmWin == 2'h1))
				begin
					// window ran out unused
					n.csr[5:0] = 6'h00;
					n.st = ST_IDLE;
				end
			end
			ST_BUSY:
			begin
				if (r.progCnt == '0)
				begin
					n.csr[5:0] = 6'h00;
					n.cpuHalt = 1'b0;
					n.st = ST_IDLE;
				end
				else
					n.progCnt = r.progCnt - CNT_W'(1);
			end
			default:
				n = REGS_RESET;
		endcase
		// software write; a store in the same cycle takes precedence
		if (regWr && hit && !cpuReq.spm && r.st != ST_BUSY)
		begin
			n.csr[BIT_IRQ_EN] = regWdata[BIT_IRQ_EN];
			if (patLegal(regWdata[5:0]))
			begin
				n.csr[5:0] = regWdata[5:0];
				n.st = ST_ARMED;
				n.spmWin = SPM_WINDOW;
				n.lpmWin = LPM_WINDOW;
				if (regWdata[BIT_REEN] && r.bufLoaded)
				begin
					// partially filled buffer is lost
					n.fl.bufAbort = 1'b1;
					n.bufLoaded = 1'b0;
				end
			end
		end
		else if (regWr && hit && !cpuReq.spm)
			n.csr[BIT_IRQ_EN] = regWdata[BIT_IRQ_EN];
	end

	// ==========================================
	// state register
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			r <= REGS_RESET;
		else
			r <= n;
	end

	assign regRdata   = r.rdata;
	assign lpmData    = r.lpmData;
	assign lpmValid   = r.lpmValid;
	assign cpuHalt    = r.cpuHalt;
	assign rwwBlocked = r.csr[BIT_RWW_BSY];
	assign readyIrq   = r.irq;
	assign bootStart  = r.bootStart;
	assign flashCmd   = r.fl;

	// ==========================================
	// checks
	logic [CNT_W-1:0] busyLen;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			busyLen <= '0;
		else if (r.st == ST_BUSY)
			busyLen <= busyLen + CNT_W'(1);
		else
			busyLen <= '0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	chk_irq_level: assert property (
		readyIrq |-> $past(r.csr[BIT_IRQ_EN]) && $past(globalIrqEn) && !$past(r.csr[BIT_EN]))
		else $error("ready interrupt without its enables");
	chk_busy_hold: assert property (
		r.st == ST_BUSY |-> r.csr[BIT_EN])
		else $error("enable bit dropped during programming");
	chk_win_expire: assert property (
		r.st == ST_ARMED && r.spmWin == 3'h1 && !cpuReq.spm && !regWr |=> !r.csr[BIT_EN])
		else $error("store window did not expire");
	chk_halt_section: assert property (
		(flashCmd.erase || flashCmd.write) && inHaltSection(flashCmd.page) |-> cpuHalt throughout (r.st == ST_BUSY))
		else $error("halt missing for halting section");
	chk_rww_set: assert property (
		(flashCmd.erase || flashCmd.write) && !inHaltSection(flashCmd.page) |-> rwwBlocked && !cpuHalt)
		else $error("section busy not set");
	chk_rww_load_clr: assert property (
		flashCmd.bufWrite |-> !rwwBlocked && flashCmd.word == $past(cpuReq.zPtr[7:1]))
		else $error("buffer load wrong or busy not cleared");
	chk_prog_len: assert property (
		r.st == ST_IDLE && $past(r.st) == ST_BUSY |-> $past(busyLen) == PROG_LAST)
		else $error("programming time wrong");
	chk_bad_pattern: assert property (
		regWr && hit && !patLegal(regWdata[5:0]) && r.st == ST_IDLE |=> r.csr[5:0] == 6'h00)
		else $error("illegal pattern accepted");
	chk_busy_ignore: assert property (
		r.st == ST_BUSY && r.progCnt != '0 |=> $stable(r.csr[5:0]))
		else $error("command bits changed while busy");
	chk_sig_read: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_SIG && cpuReq.lpm && r.lpmWin != 2'h0
		|=> lpmValid && lpmData == $past(sigRowByte))
		else $error("signature byte not returned");
	chk_page_addr: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_PGER && cpuReq.spm
		|=> flashCmd.erase && flashCmd.page == $past(cpuReq.zPtr[16:8]))
		else $error("erase page wrong");
	// boot start lags the fuses by one edge, so the first edge after reset has no history
	chk_boot_start: assert property (
		$past(rst_b) |-> bootStart == bootStartOf($past(bootSizeFuses)))
		else $error("boot start wrong");

	// ==========================================
	// command decode, halt, window and register access checks
	chk_lpm_pulse: assert property (
		lpmValid |=> !lpmValid)
		else $error("load result held longer than one cycle");
	chk_halt_idle: assert property (
		r.st != ST_BUSY |-> !cpuHalt)
		else $error("processor halted outside programming");
	chk_lock_data: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_LOCK && cpuReq.spm
		|=> flashCmd.lockWrite && flashCmd.lockData == $past(cpuReq.r1r0[7:0]))
		else $error("lock bits not taken from low byte");
	chk_write_page: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_PGWR && cpuReq.spm
		|=> flashCmd.write && flashCmd.page == $past(cpuReq.zPtr[16:8]))
		else $error("write page wrong");
	chk_reen_clear: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_REEN && cpuReq.spm |=> !rwwBlocked)
		else $error("section not re-enabled");
	chk_fill_abort: assert property (
		regWr && hit && regWdata[5:0] == PAT_REEN && r.bufLoaded && !cpuReq.spm && r.st != ST_BUSY
		|=> flashCmd.bufAbort && !r.bufLoaded)
		else $error("buffer fill not aborted");
	chk_win_open: assert property (
		regWr && hit && patLegal(regWdata[5:0]) && !cpuReq.spm && r.st != ST_BUSY
		|=> r.st == ST_ARMED && r.spmWin == SPM_WINDOW && r.csr[BIT_EN])
		else $error("store window not opened");
	chk_csr_read: assert property (
		regRd && hit |=> regRdata == $past(r.csr))
		else $error("register read wrong");
	chk_sig_store: assert property (
		r.st == ST_ARMED && r.csr[5:0] == PAT_SIG && cpuReq.spm
		|=> !(flashCmd.erase || flashCmd.write || flashCmd.bufWrite || flashCmd.lockWrite) && r.st == ST_IDLE)
		else $error("store during signature read acted");
endmodule

`default_nettype wire

/* spf_self_program_flash_control_bench.sv */
// self-checking bench of the self-programming flash control block
`timescale 1ns/1ps
`default_nettype none
module spf_self_program_flash_control_bench;
	import spf_pkg::*;
	localparam int PC = 40;
	typedef struct packed {logic [47:0] v; logic [47:0] m;} spf_note_type;
	logic              ref_clk = 0, rst_b = 0, regWr = 0, regRd = 0, regIsIo = 0, globalIrqEn = 0;
	logic [7:0]        regAddr = '0, regWdata = '0, sigRowByte = '0, lockBits = '0;
	logic [7:0]        fuseLow = '0, fuseHigh = '0, fuseExt = '0, regRdata, lpmData;
	logic [1:0]        bootSizeFuses = '0;
	logic              lpmValid, cpuHalt, rwwBlocked, readyIrq, rdFlag = 0, b6 = 0;
	logic [15:0]       bootStart, d;
	logic [16:0]       z;
	spf_cpu_req_type   cpuReq;
	spf_flash_cmd_type flashCmd;
	spf_note_type      q[$];
	int                bad_count = 0, num_checks = 0, cyc = 0, i;

	spf_self_program_flash_control #(.PROG_CYCLES(PC)) u_dut (.ref_clk, .rst_b, .regWr, .regRd, .regIsIo,
		.regAddr, .regWdata, .regRdata, .cpuReq, .globalIrqEn, .bootSizeFuses, .sigRowByte, .lockBits,
		.fuseLow, .fuseHigh, .fuseExt, .lpmData, .lpmValid, .cpuHalt, .rwwBlocked, .readyIrq, .bootStart,
		.flashCmd);
	spf_cpu_model u_cpu (.cpuReq, .ref_clk);
	always #25 ref_clk = ~ref_clk;

	// ==========================================
	// checking and bus tasks
	task automatic chk(input logic [47:0] s, input logic [47:0] e);
		num_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic note(input logic [2:0] t, input logic [44:0] v, input logic [44:0] m);
		q.push_back({{t, v}, {3'h7, m}});
	endtask
	// an empty queue yields a zero value under a full mask, so any event then fails
	task automatic got(input logic [47:0] s);
		spf_note_type n;
		n = q.size() ? q.pop_front() : spf_note_type'({48'h0, {48{1'b1}}});
		chk(s & n.m, n.v & n.m);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		regWr <= w;
		regRd <= !w;
		regIsIo <= a == CSR_IO_OFS;
		regAddr <= a;
		regWdata <= v;
		@(posedge ref_clk);
		regWr <= 0;
		regRd <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		note(3'h2, {37'h0, e}, 45'hff);
		bus(0, a, 8'h00);
	endtask
	task automatic prog(input logic [5:0] pat, input logic [8:0] p);
		logic lck;
		logic concurrent_read_section;
		logic [15:0] v;
		lck = pat == PAT_LOCK;
		concurrent_read_section = !lck && p < HALT_FIRST_PAGE;
		v = 16'($urandom());
		b6 |= concurrent_read_section;
		note(3'h4, {pat == PAT_PGER, pat == PAT_PGWR, 2'b0, lck, p, 23'h0, v[7:0]},
			{5'h1f, {9{!lck}}, 23'h0, {8{lck}}});
		bus(1, CSR_DATA_OFS, {2'b0, pat});
		u_cpu.op(1, {p, 8'h0}, v, $urandom_range(0, 3));
		bus(1, CSR_DATA_OFS, {2'b00, PAT_LOAD});
		@(negedge ref_clk);
		chk(48'({cpuHalt, rwwBlocked}), 48'({!lck && !concurrent_read_section, b6}));
		rd(CSR_DATA_OFS, {1'b0, b6, pat});
		repeat (PC) @(posedge ref_clk);
		rd(CSR_DATA_OFS, {1'b0, b6, 6'h0});
	endtask
	task automatic wrap_up();
		if (q.size() != 0)
			bad_count++;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================
	// result watcher and hang limit
	always @(negedge ref_clk)
	begin
		if (rdFlag)
			got({3'h2, 37'h0, regRdata});
		if (lpmValid !== 1'b0)
			got({3'h1, 37'h0, lpmData});
		if (flashCmd[44:40] !== 5'h0)
			got({3'h4, flashCmd});
		rdFlag = regRd && (regIsIo ? regAddr == CSR_IO_OFS : regAddr == CSR_DATA_OFS);
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	// ==========================================
	// scenarios
	initial
	begin
		void'($urandom(91245));
		{sigRowByte, lockBits, fuseLow, fuseHigh, fuseExt} = 40'({$urandom(), $urandom()});
		repeat (8) @(posedge ref_clk);
		rst_b <= 1;
		rd(CSR_DATA_OFS, CSR_RESET);
		rd(CSR_IO_OFS, CSR_RESET);
		bus(0, 8'h99, 8'h00);
		@(negedge ref_clk);
		chk(48'(regRdata), 48'(CSR_RESET));
		$display("test registers done");
		z = 17'($urandom());
		d = 16'($urandom());
		note(3'h4, {5'b00100, 9'h0, z[7:1], d, 8'h0}, {5'h1f, 9'h0, 7'h7f, 16'hffff, 8'h0});
		bus(1, CSR_DATA_OFS, {2'b00, PAT_LOAD});
		u_cpu.op(1, z, d, $urandom_range(0, 3));
		note(3'h4, {5'b00010, 40'h0}, {5'h1f, 40'h0});
		bus(1, CSR_IO_OFS, {2'b00, PAT_REEN});
		u_cpu.op(1, z, d, 1);
		$display("test buffer done");
		prog(PAT_PGER, HALT_FIRST_PAGE - 9'h1);
		note(3'h4, {5'b00100, 9'h0, 7'h0, d, 8'h0}, {5'h1f, 9'h0, 7'h7f, 16'hffff, 8'h0});
		bus(1, CSR_DATA_OFS, {2'b00, PAT_LOAD});
		u_cpu.op(1, '0, d, 0);
		b6 = 0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(48'(rwwBlocked), 48'h0);
		prog(PAT_PGWR, HALT_FIRST_PAGE);
		prog(PAT_PGER, 9'($urandom_range(0, 479)));
		bus(1, CSR_IO_OFS, {2'b00, PAT_REEN});
		u_cpu.op(1, '0, '0, 2);
		b6 = 0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(48'(rwwBlocked), 48'h0);
		prog(PAT_LOCK, 9'h0);
		$display("test programming done");
		for (i = 0; i < 4; i++)
		begin
			note(3'h1, {37'h0, i[1] ? (i[0] ? fuseHigh : fuseExt) : (i[0] ? lockBits : fuseLow)}, 45'hff);
			bus(1, CSR_DATA_OFS, {2'b00, PAT_LOCK});
			u_cpu.op(0, 17'(i), '0, $urandom_range(0, 2));
		end
		note(3'h1, {37'h0, sigRowByte}, 45'hff);
		bus(1, CSR_DATA_OFS, {2'b00, PAT_SIG});
		u_cpu.op(0, '0, '0, 1);
		bus(1, CSR_DATA_OFS, {2'b00, PAT_SIG});
		u_cpu.op(1, '0, d, 0);
		rd(CSR_DATA_OFS, 8'h00);
		$display("test loads done");
		// bit 7 kept clear so only the command bits are judged
		for (i = 0; i < 6; i++)
		begin
			bus(1, CSR_DATA_OFS, 8'h3f & (8'h07 << i));
			rd(CSR_DATA_OFS, 8'h00);
		end
		$display("test patterns done");
		bus(1, CSR_DATA_OFS, 8'h81);
		globalIrqEn <= 1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk(48'(readyIrq), 48'h0);
		u_cpu.op(0, '0, '0, 1);
		u_cpu.op(1, '0, d, 2);
		rd(CSR_DATA_OFS, 8'h80);
		@(negedge ref_clk);
		chk(48'(readyIrq), 48'h1);
		$display("test window done");
		for (i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			bootSizeFuses <= i[1:0];
			repeat (2) @(posedge ref_clk);
			@(negedge ref_clk);
			chk(48'(bootStart), 48'(17'h10000 - (17'h1000 >> i)));
		end
		$display("test boot size done");
		wrap_up();
	end
endmodule
`default_nettype wire
